// ---- pkg/clkgen_pkg.sv ----
// constants, register map and encodings of the system clock generator
// How it works
// RULE1: one of three sources, strap selected
// RULE2: fast ring nominal 8 MHz, halts on stop
// RULE3: stop gates external clock, halts resonator
// RULE4: fast ring frees both oscillator pins
// RULE5: external clock drives first pin, frees second
// RULE6: slow ring 240 kHz feeds interval timers
// RULE7: slow mode register works only if allowed
// RULE8: otherwise writes ignored, watchdog source forced
// RULE9: both divider registers reset to 02H
// RULE10: divider registers take bit and byte writes
// RULE11: cpu clock from three divide bits; the code uses the single bit CPU_DIV_BIT, divide by one or four
// RULE12: peripheral clock halves or quarters system clock
// RULE13: fastest instruction lasts two cpu clocks
// RULE14: slow mode resets 00H, bit 4 halts
// RULE15: divider 00H passes system clock undivided
// RULE16: ratio changes never shorten a clock pulse
package clkgen_pkg;
   // register byte addresses on the cpu data space
   localparam logic [15:0] PERIPH_DIV_ADDR = 16'hFFF3;
   localparam logic [15:0] CPU_DIV_ADDR    = 16'hFFFB;
   localparam logic [15:0] SLOW_MODE_ADDR  = 16'hFF58;
   // reset values
   localparam logic [7:0]  DIV_RESET       = 8'h02;
   localparam logic [7:0]  SLOW_RESET      = 8'h00;
   // field positions
   localparam int          CPU_DIV_BIT     = 1;
   localparam int          PERIPH_HI_BIT   = 1;
   localparam int          PERIPH_LO_BIT   = 0;
   localparam int          SLOW_HALT_BIT   = 4;
   // writable masks, other bits read as zero
   localparam logic [7:0]  CPU_DIV_MASK    = 8'h02;
   localparam logic [7:0]  PERIPH_MASK     = 8'h03;
   localparam logic [7:0]  SLOW_MASK       = 8'h10;
   // clock source strap codes
   localparam logic [1:0]  SRC_FAST_RING   = 2'h0;
   localparam logic [1:0]  SRC_RESONATOR   = 2'h1;
   localparam logic [1:0]  SRC_EXTERNAL    = 2'h2;
   // rates in kHz; ring oscillators are fractional tick generators
   localparam int          CLK_KHZ         = 100000;
   localparam int          FAST_OSC_KHZ    = 8000;
   localparam int          SLOW_OSC_KHZ    = 240;
   localparam int          ACC_W           = 17;
   localparam logic [ACC_W-1:0] ACC_MOD    = ACC_W'(CLK_KHZ);
   localparam logic [ACC_W-1:0] FAST_STEP  = ACC_W'(FAST_OSC_KHZ);
   localparam logic [ACC_W-1:0] SLOW_STEP  = ACC_W'(SLOW_OSC_KHZ);
   // divide shifts of the prescaler
   localparam logic [2:0]  SHIFT_DIV1      = 3'h0;
   localparam logic [2:0]  SHIFT_DIV2      = 3'h1;
   localparam logic [2:0]  SHIFT_DIV4      = 3'h2;
   // cpu clocks per fastest instruction
   localparam logic [1:0]  INSN_CLOCKS     = 2'h2;
endpackage

// ---- rtl/tick_divider.sv ----
// power-of-two tick divider that changes ratio only on a period boundary
`timescale 1ns/1ps
module tick_divider (
   input  wire logic       clk_i,
   input  wire logic       rstn_i,
   input  wire logic       ce_i,
   input  wire logic       tick_i,
   input  wire logic [2:0] shift_i,
   input  wire logic [2:0] shift_rst_i,
   output logic            tick_o
);
   logic [3:0] cnt;
   logic [2:0] shift_cur;
   logic [3:0] mask;

   // terminal count mask of the active ratio
   always_comb begin
      case (shift_cur)
         3'h0:    mask = 4'h0;
         3'h1:    mask = 4'h1;
         3'h2:    mask = 4'h3;
         3'h3:    mask = 4'h7;
         default: mask = 4'hF;
      endcase
   end

   // count input ticks; a new ratio loads only when a period ends
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         cnt       <= 4'h0;
         shift_cur <= shift_rst_i;
         tick_o    <= 1'b0;
      end else if (ce_i) begin
         tick_o <= 1'b0;
         if (tick_i) begin
            if ((cnt & mask) == mask) begin
               tick_o    <= 1'b1;
               cnt       <= 4'h0;
               shift_cur <= shift_i; // RULE16
            end else begin
               cnt <= cnt + 4'h1;
            end
         end
      end
   end
endmodule

// ---- rtl/sysclk_gen.sv ----
// system clock source selection, prescaler and slow interval clock
`timescale 1ns/1ps
module sysclk_gen (
   input  wire logic        CLK_I,
   input  wire logic        RSTN_I,
   input  wire logic        CE_I,
   // option byte straps, caught once after reset
   input  wire logic [1:0]  CLK_SRC_SEL_I,
   input  wire logic        SLOW_STOP_ALLOWED_I,
   // cpu is executing the stop-mode instruction
   input  wire logic        STOP_I,
   // first oscillator pin level
   input  wire logic        OSC_PIN_IN_I,
   // cpu memory access port
   input  wire logic [15:0] ADDR_I,
   input  wire logic        WR_I,
   input  wire logic [7:0]  WDATA_I,
   input  wire logic        BIT_WR_I,
   input  wire logic [2:0]  BIT_SEL_I,
   input  wire logic        BIT_VAL_I,
   input  wire logic        RD_I,
   output logic [7:0]       RDATA_O,
   // clock enables of the derived clocks and the watchdog source forced flag
   output logic             SYS_TICK_O,
   output logic             PERIPH_TICK_O,
   output logic             CPU_TICK_O,
   output logic             INSN_TICK_O,
   output logic             SLOW_TICK_O,
   output logic             WDT_SRC_FORCED_O,
   // pin release and resonator drive
   output logic             OSC_PIN_IN_GPIO_O,
   output logic             OSC_PIN_OUT_GPIO_O,
   output logic             OSC_PIN_OUT_O,
   output logic             OSC_PIN_OUT_OE_O
);
   typedef enum logic [1:0] {
      SRC_FAST,
      SRC_RES,
      SRC_EXT
   } src_t;

   logic                             strap_done;
   src_t                             src;
   logic                             slow_allowed;
   logic [7:0]                       periph_div;
   logic [7:0]                       cpu_div;
   logic [7:0]                       slow_mode;
   logic                             pin_q;
   logic                             pin_rise;
   logic                             fast_tick;
   logic                             slow_tick;
   logic                             slow_run;
   logic                             fast_run;
   logic                             next_sys_tick;
   logic [2:0]                       periph_shift;
   logic [2:0]                       cpu_shift;
   logic                             periph_tick;
   logic                             cpu_tick;
   logic                             insn_phase;
   logic [clkgen_pkg::ACC_W-1:0]     acc [2];
   logic [1:0]                       osc_tick;
   logic [1:0]                       osc_run;

   // catch the option straps once, in the first enabled cycle after reset;
   // later strap movement cannot swap the clock source under a running cpu,
   // and every consumer below waits for strap_done so nothing ticks from
   // a source that was never chosen
   always_ff @(posedge CLK_I) begin
      if (!RSTN_I) begin
         strap_done   <= 1'b0;
         src          <= SRC_FAST;
         slow_allowed <= 1'b0;
      end else if (CE_I && !strap_done) begin
         strap_done   <= 1'b1;
         slow_allowed <= SLOW_STOP_ALLOWED_I;
         case (CLK_SRC_SEL_I) // RULE1
            clkgen_pkg::SRC_RESONATOR: src <= SRC_RES;
            clkgen_pkg::SRC_EXTERNAL:  src <= SRC_EXT;
            default:                   src <= SRC_FAST;
         endcase
      end
   end

   // peripheral divider register, byte or single bit writes
   // reserved bits are masked on byte writes and refused on bit writes,
   // so they always read zero; a byte write wins over a bit write
   always_ff @(posedge CLK_I) begin
      if (!RSTN_I) begin
         periph_div <= clkgen_pkg::DIV_RESET; // RULE9
      end else if (CE_I && ADDR_I == clkgen_pkg::PERIPH_DIV_ADDR) begin
         if (WR_I) begin
            periph_div <= WDATA_I & clkgen_pkg::PERIPH_MASK;
         end else if (BIT_WR_I && clkgen_pkg::PERIPH_MASK[BIT_SEL_I]) begin
            periph_div[BIT_SEL_I] <= BIT_VAL_I; // RULE10
         end
      end
   end

   // cpu divider register, byte or single bit writes
   // only the divide bit is kept, the rest reads zero
   always_ff @(posedge CLK_I) begin
      if (!RSTN_I) begin
         cpu_div <= clkgen_pkg::DIV_RESET; // RULE9
      end else if (CE_I && ADDR_I == clkgen_pkg::CPU_DIV_ADDR) begin
         if (WR_I) begin
            cpu_div <= WDATA_I & clkgen_pkg::CPU_DIV_MASK;
         end else if (BIT_WR_I && clkgen_pkg::CPU_DIV_MASK[BIT_SEL_I]) begin
            cpu_div[BIT_SEL_I] <= BIT_VAL_I; // RULE10
         end
      end
   end

   // slow mode register, byte writes only, dead unless the strap allows
   // a forbidden strap leaves the register at its reset value, so a stray
   // write can never halt the watchdog clock
   always_ff @(posedge CLK_I) begin
      if (!RSTN_I) begin
         slow_mode <= clkgen_pkg::SLOW_RESET; // RULE14
      end else if (CE_I && WR_I && slow_allowed && strap_done &&
                   ADDR_I == clkgen_pkg::SLOW_MODE_ADDR) begin
         slow_mode <= WDATA_I & clkgen_pkg::SLOW_MASK; // RULE7 RULE8
      end
   end

   // registered read port; unmapped addresses read zero
   // the data holds between reads, so a slow consumer may sample late
   always_ff @(posedge CLK_I) begin
      if (!RSTN_I) begin
         RDATA_O <= 8'h00;
      end else if (CE_I && RD_I) begin
         case (ADDR_I)
            clkgen_pkg::PERIPH_DIV_ADDR: RDATA_O <= periph_div;
            clkgen_pkg::CPU_DIV_ADDR:    RDATA_O <= cpu_div;
            clkgen_pkg::SLOW_MODE_ADDR:  RDATA_O <= slow_mode;
            default:                     RDATA_O <= 8'h00;
         endcase
      end
   end

   // run conditions of the two ring oscillators
   assign fast_run = strap_done && !STOP_I; // RULE2
   assign slow_run = strap_done &&
                     !(slow_allowed && slow_mode[clkgen_pkg::SLOW_HALT_BIT]); // RULE7 RULE8 RULE14
   assign osc_run  = {slow_run, fast_run};

   // ring oscillators as fractional accumulators at their nominal rates
   // each adds its rate in kHz every cycle and ticks when the sum passes
   // the core clock rate; the average rate is exact while single periods
   // differ by one cycle, so consumers must not count on an even spacing
   // the remainder is kept while a ring is halted
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_ring
         localparam logic [clkgen_pkg::ACC_W-1:0] STEP =
            (gi == 0) ? clkgen_pkg::FAST_STEP : clkgen_pkg::SLOW_STEP;
         logic [clkgen_pkg::ACC_W-1:0] sum;
         assign sum = acc[gi] + STEP;
         always_ff @(posedge CLK_I) begin
            if (!RSTN_I) begin
               acc[gi]      <= '0;
               osc_tick[gi] <= 1'b0;
            end else if (CE_I) begin
               osc_tick[gi] <= 1'b0;
               if (osc_run[gi]) begin
                  if (sum >= clkgen_pkg::ACC_MOD) begin
                     acc[gi]      <= sum - clkgen_pkg::ACC_MOD; // RULE2 RULE6
                     osc_tick[gi] <= 1'b1;
                  end else begin
                     acc[gi] <= sum;
                  end
               end
            end
         end
      end
   endgenerate

   // per-oscillator ticks under readable names
   assign fast_tick = osc_tick[0];
   assign slow_tick = osc_tick[1];

   // first oscillator pin history for edge detection
   // the history resets low, the level the pin rests at outside a clock;
   // a rise caught before the straps settle is masked by strap_done
   always_ff @(posedge CLK_I) begin
      if (!RSTN_I) begin
         pin_q <= 1'b0;
      end else if (CE_I) begin
         pin_q <= OSC_PIN_IN_I;
      end
   end

   assign pin_rise = OSC_PIN_IN_I && !pin_q;

   // pick the one system clock source; stop gates pin based clocks
   // the fast ring halts by itself, so it needs no gate here
   always_comb begin
      case (src) // RULE1
         SRC_FAST: next_sys_tick = fast_tick;
         SRC_RES:  next_sys_tick = pin_rise && !STOP_I; // RULE3
         SRC_EXT:  next_sys_tick = pin_rise && !STOP_I; // RULE3 RULE5
         default:  next_sys_tick = 1'b0;
      endcase
   end

   // registered system tick; the register keeps the pin path and the ring
   // path equally late, one cycle after the source event
   always_ff @(posedge CLK_I) begin
      if (!RSTN_I) begin
         SYS_TICK_O <= 1'b0;
      end else if (CE_I) begin
         SYS_TICK_O <= next_sys_tick && strap_done;
      end
   end

   // peripheral divide ratio; the prohibited code 11 falls back to quarter
   // so a bad write still gives a legal, slower clock
   always_comb begin
      case (periph_div[clkgen_pkg::PERIPH_HI_BIT:clkgen_pkg::PERIPH_LO_BIT])
         2'h0:    periph_shift = clkgen_pkg::SHIFT_DIV1; // RULE15
         2'h1:    periph_shift = clkgen_pkg::SHIFT_DIV2; // RULE12
         default: periph_shift = clkgen_pkg::SHIFT_DIV4; // RULE12
      endcase
   end

   // the cpu clock divides the peripheral clock once more by one or four
   // the cpu stage counts peripheral ticks, never system ticks
   assign cpu_shift = cpu_div[clkgen_pkg::CPU_DIV_BIT] ?
                      clkgen_pkg::SHIFT_DIV4 : clkgen_pkg::SHIFT_DIV1; // RULE11

   // prescaler stage for the peripheral clock
   // both stages start at quarter rate to match the reset value of the
   // dividers, so the first periods after reset are already full length
   tick_divider u_periph_div (
      .clk_i       (CLK_I),
      .rstn_i      (RSTN_I),
      .ce_i        (CE_I),
      .tick_i      (SYS_TICK_O),
      .shift_i     (periph_shift),
      .shift_rst_i (clkgen_pkg::SHIFT_DIV4),
      .tick_o      (periph_tick)
   );

   // cpu stage chained behind the peripheral clock
   // a ratio change here waits for the end of its own longer period
   tick_divider u_cpu_div (
      .clk_i       (CLK_I),
      .rstn_i      (RSTN_I),
      .ce_i        (CE_I),
      .tick_i      (periph_tick),
      .shift_i     (cpu_shift),
      .shift_rst_i (clkgen_pkg::SHIFT_DIV4),
      .tick_o      (cpu_tick)
   );

   // both outputs come straight from the divider flip-flops
   assign PERIPH_TICK_O = periph_tick;
   assign CPU_TICK_O    = cpu_tick;

   // instruction slot marker every second cpu clock
   // the first marker falls on the second cpu tick after reset
   always_ff @(posedge CLK_I) begin
      if (!RSTN_I) begin
         insn_phase  <= 1'b0;
         INSN_TICK_O <= 1'b0;
      end else if (CE_I) begin
         INSN_TICK_O <= 1'b0;
         if (cpu_tick) begin
            insn_phase  <= ~insn_phase;
            INSN_TICK_O <= (2'(insn_phase) == clkgen_pkg::INSN_CLOCKS - 2'h1); // RULE13
         end
      end
   end

   // interval clock to watchdog and 8-bit interval timer
   // the forced flag tells the watchdog that its source is fixed to the
   // slow ring and that the slow ring cannot be halted
   always_ff @(posedge CLK_I) begin
      if (!RSTN_I) begin
         SLOW_TICK_O      <= 1'b0;
         WDT_SRC_FORCED_O <= 1'b0;
      end else if (CE_I) begin
         SLOW_TICK_O      <= slow_tick; // RULE6
         WDT_SRC_FORCED_O <= strap_done && !slow_allowed; // RULE8
      end
   end

   // oscillator pin release and resonator amplifier drive
   // the pins stay claimed until the straps are known, so a resonator
   // never sees a port driver at power up; the drive stops in stop mode
   always_ff @(posedge CLK_I) begin
      if (!RSTN_I) begin
         OSC_PIN_IN_GPIO_O  <= 1'b0;
         OSC_PIN_OUT_GPIO_O <= 1'b0;
         OSC_PIN_OUT_O      <= 1'b0;
         OSC_PIN_OUT_OE_O   <= 1'b0;
      end else if (CE_I) begin
         OSC_PIN_IN_GPIO_O  <= strap_done && src == SRC_FAST; // RULE4
         OSC_PIN_OUT_GPIO_O <= strap_done && src != SRC_RES; // RULE4 RULE5
         OSC_PIN_OUT_O      <= !OSC_PIN_IN_I;
         OSC_PIN_OUT_OE_O   <= strap_done && src == SRC_RES && !STOP_I; // RULE3
      end
   end
endmodule

// ---- dv/ext_clk_model.sv ----
// external clock source that drives the first oscillator pin
`timescale 1ns/1ps
module ext_clk_model #(
   parameter int HALF = 2
) (
   input  wire logic clk_i,
   input  wire logic en_i,
   output logic      pin_o
);
   int cnt = 0;
   initial pin_o = 1'b0;
   // toggles every HALF cycles while enabled, rests low otherwise
   always @(posedge clk_i) begin
      if (!en_i) begin
         pin_o <= #1 1'b0;
         cnt <= 0;
      end else if (cnt == HALF - 1) begin
         pin_o <= #1 ~pin_o;
         cnt <= 0;
      end else begin
         cnt <= cnt + 1;
      end
   end
endmodule

// ---- dv/sysclk_gen_chk.sv ----
// assertion checker for the system clock generator
`timescale 1ns/1ps
module sysclk_gen_chk (
   input wire logic       CLK_I,
   input wire logic       RSTN_I,
   input wire logic [1:0] CLK_SRC_SEL_I,
   input wire logic       SLOW_STOP_ALLOWED_I,
   input wire logic       STOP_I,
   input wire logic       SYS_TICK_O,
   input wire logic       PERIPH_TICK_O,
   input wire logic       CPU_TICK_O,
   input wire logic       INSN_TICK_O,
   input wire logic       SLOW_TICK_O,
   input wire logic       WDT_SRC_FORCED_O,
   input wire logic       OSC_PIN_IN_GPIO_O,
   input wire logic       OSC_PIN_OUT_GPIO_O,
   input wire logic       OSC_PIN_OUT_OE_O
);
   logic [9:0] slow_gap;
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (!RSTN_I);
   // cycles since the last slow tick, saturating
   always_ff @(posedge CLK_I) begin
      if (!RSTN_I || SLOW_TICK_O) slow_gap <= 10'h000;
      else if (slow_gap != 10'h3FF) slow_gap <= slow_gap + 10'h001;
   end
   chk_periph_after_sys: assert property (PERIPH_TICK_O |-> $past(SYS_TICK_O))
      else $error("peripheral tick without system tick");
   chk_cpu_after_periph: assert property (CPU_TICK_O |-> $past(PERIPH_TICK_O))
      else $error("cpu tick without peripheral tick");
   chk_insn_after_cpu: assert property (INSN_TICK_O |-> $past(CPU_TICK_O))
      else $error("instruction tick without cpu tick");
   chk_stop_no_sys: assert property (STOP_I [*3] |=> !SYS_TICK_O)
      else $error("system tick during stop");
   chk_fast_pins_free: assert property ((CLK_SRC_SEL_I == 2'h0) [*3] |->
      OSC_PIN_IN_GPIO_O && OSC_PIN_OUT_GPIO_O)
      else $error("fast ring leaves a pin claimed");
   chk_ext_pin_free: assert property ((CLK_SRC_SEL_I == 2'h2) [*3] |->
      OSC_PIN_OUT_GPIO_O && !OSC_PIN_IN_GPIO_O && !OSC_PIN_OUT_OE_O)
      else $error("external clock pin use wrong");
   chk_wdt_src_forced: assert property (!SLOW_STOP_ALLOWED_I [*3] |-> WDT_SRC_FORCED_O)
      else $error("watchdog source not forced");
   chk_slow_keeps_on: assert property (WDT_SRC_FORCED_O |-> slow_gap < 10'h1A4)
      else $error("slow ring stopped while forced");
   chk_slow_rate_low: assert property (SLOW_TICK_O |-> slow_gap >= 10'h19A)
      else $error("slow tick too early");
   cover property (INSN_TICK_O);
   cover property (SLOW_TICK_O && WDT_SRC_FORCED_O);
   cover property (STOP_I && OSC_PIN_OUT_GPIO_O);
endmodule
bind sysclk_gen sysclk_gen_chk chk (.CLK_I(CLK_I), .RSTN_I(RSTN_I), .CLK_SRC_SEL_I(CLK_SRC_SEL_I),
   .SLOW_STOP_ALLOWED_I(SLOW_STOP_ALLOWED_I), .STOP_I(STOP_I), .SYS_TICK_O(SYS_TICK_O),
   .PERIPH_TICK_O(PERIPH_TICK_O), .CPU_TICK_O(CPU_TICK_O), .INSN_TICK_O(INSN_TICK_O),
   .SLOW_TICK_O(SLOW_TICK_O), .WDT_SRC_FORCED_O(WDT_SRC_FORCED_O), .OSC_PIN_IN_GPIO_O(OSC_PIN_IN_GPIO_O),
   .OSC_PIN_OUT_GPIO_O(OSC_PIN_OUT_GPIO_O), .OSC_PIN_OUT_OE_O(OSC_PIN_OUT_OE_O));

// ---- dv/sysclk_gen_bench.sv ----
// self-checking bench of the system clock generator
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
   $display("ERROR %0t got %0h exp %0h", $time, g, e); end end
module sysclk_gen_bench;
   logic        clk = 1'b0, rstn = 1'b0, stop = 1'b0, allow = 1'b1, wr = 1'b0, bw = 1'b0, bval = 1'b0, rd = 1'b0;
   logic        pin, sys_t, per_t, cpu_t, ins_t, slw_t, forced, in_gp, out_gp, oe, pout;
   logic [1:0]  sel = 2'h2;
   logic [2:0]  bsel = 3'h0;
   logic [7:0]  wdata = 8'h00, rdata;
   logic [15:0] addr = 16'h0000;
   int          n_fail = 0, n_checks = 0;
   always #5 clk = ~clk;
   ext_clk_model #(.HALF(2)) osc (.clk_i(clk), .en_i(sel != 2'h0), .pin_o(pin));
   sysclk_gen uut (.CLK_I(clk), .RSTN_I(rstn), .CE_I(1'b1), .CLK_SRC_SEL_I(sel), .SLOW_STOP_ALLOWED_I(allow),
      .STOP_I(stop), .OSC_PIN_IN_I(pin), .ADDR_I(addr), .WR_I(wr), .WDATA_I(wdata), .BIT_WR_I(bw),
      .BIT_SEL_I(bsel), .BIT_VAL_I(bval), .RD_I(rd), .RDATA_O(rdata), .SYS_TICK_O(sys_t), .PERIPH_TICK_O(per_t),
      .CPU_TICK_O(cpu_t), .INSN_TICK_O(ins_t), .SLOW_TICK_O(slw_t), .WDT_SRC_FORCED_O(forced),
      .OSC_PIN_IN_GPIO_O(in_gp), .OSC_PIN_OUT_GPIO_O(out_gp), .OSC_PIN_OUT_O(pout), .OSC_PIN_OUT_OE_O(oe));
   task automatic step(input int n = 1);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // register accesses, one strobe cycle then one idle cycle
   task automatic wr8(input logic [15:0] a, input logic [7:0] d);
      addr = a;
      wdata = d;
      wr = 1'b1;
      step();
      wr = 1'b0;
      step();
   endtask
   task automatic bwr(input logic [15:0] a, input logic [2:0] s, input logic v);
      addr = a;
      bsel = s;
      bval = v;
      bw = 1'b1;
      step();
      bw = 1'b0;
      step();
   endtask
   task automatic rdchk(input logic [15:0] a, input logic [7:0] e);
      addr = a;
      rd = 1'b1;
      step();
      rd = 1'b0;
      step();
      `CHK(rdata, e)
   endtask
   task automatic reboot(input logic [1:0] s, input logic a);
      rstn = 1'b0;
      sel = s;
      allow = a;
      step(3);
      rstn = 1'b1;
      step(3);
   endtask
   task automatic count(input int n, output int ns, output int nl);
      ns = 0;
      nl = 0;
      repeat (n) begin
         step();
         if (sys_t === 1'b1) ns++;
         if (slw_t === 1'b1) nl++;
      end
   endtask
   task automatic halted(output int ns);
      int nl;
      stop = 1'b1;
      step(3);
      count(200, ns, nl);
      `CHK(oe, 1'b0)
      stop = 1'b0;
   endtask
   // system ticks between successive peripheral, cpu and instruction ticks
   task automatic measure(input int dp, input int dc);
      int   s[3] = '{0, 0, 0};
      int   g[3] = '{0, 0, 0};
      int   e[3] = '{0, 0, 0};
      logic t[3];
      repeat (1500) begin
         step();
         t = '{per_t, cpu_t, ins_t};
         for (int j = 0; j < 3; j++) begin
            if (t[j] === 1'b1) begin
               if (e[j] > 0) g[j] = s[j];
               e[j]++;
               s[j] = 0;
            end
            if (sys_t === 1'b1) s[j]++;
         end
      end
      `CHK(g[0], dp)
      `CHK(g[1], dc)
      `CHK(g[2], 2 * dc)
   endtask
   task automatic t_regs;
      reboot(2'h2, 1'b1);
      rdchk(clkgen_pkg::PERIPH_DIV_ADDR, 8'h02);
      rdchk(clkgen_pkg::CPU_DIV_ADDR, 8'h02);
      rdchk(clkgen_pkg::SLOW_MODE_ADDR, 8'h00);
      rdchk(16'h0000, 8'h00);
      measure(4, 16);
      wr8(clkgen_pkg::CPU_DIV_ADDR, 8'hFF);
      rdchk(clkgen_pkg::CPU_DIV_ADDR, 8'h02);
   endtask
   // every legal divider combination, cpu bit set by single-bit write
   task automatic t_ratios;
      logic [7:0] pp[6] = '{8'h00, 8'h01, 8'h00, 8'h02, 8'h01, 8'h02};
      logic       cb[6] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
      int         dp[6] = '{1, 2, 1, 4, 2, 4};
      int         dc[6] = '{1, 2, 4, 4, 8, 16};
      for (int k = 0; k < 6; k++) begin
         wr8(clkgen_pkg::PERIPH_DIV_ADDR, pp[k]);
         bwr(clkgen_pkg::CPU_DIV_ADDR, 3'h1, cb[k]);
         measure(dp[k], dc[k]);
         rdchk(clkgen_pkg::CPU_DIV_ADDR, {6'h00, cb[k], 1'b0});
      end
      wr8(clkgen_pkg::PERIPH_DIV_ADDR, 8'h03);
      measure(4, 16);
   endtask
   // a ratio change lands on a period end: the old quarter period finishes
   task automatic t_glitch;
      int ns = 0;
      int lim = 0;
      while (per_t !== 1'b1 && lim < 100) begin
         step();
         lim++;
      end
      wr8(clkgen_pkg::PERIPH_DIV_ADDR, 8'h00);
      while (per_t !== 1'b1 && lim < 200) begin
         step();
         lim++;
         if (sys_t === 1'b1) ns++;
      end
      `CHK(lim < 200, 1'b1)
      `CHK(ns, 4)
   endtask
   task automatic t_slow;
      int ns, nl;
      `CHK(forced, 1'b0)
      wr8(clkgen_pkg::SLOW_MODE_ADDR, 8'h10);
      rdchk(clkgen_pkg::SLOW_MODE_ADDR, 8'h10);
      count(900, ns, nl);
      `CHK(nl, 0)
      wr8(clkgen_pkg::SLOW_MODE_ADDR, 8'h00);
      count(900, ns, nl);
      `CHK(nl > 1, 1'b1)
      reboot(2'h2, 1'b0);
      `CHK(forced, 1'b1)
      wr8(clkgen_pkg::SLOW_MODE_ADDR, 8'h10);
      rdchk(clkgen_pkg::SLOW_MODE_ADDR, 8'h00);
      count(900, ns, nl);
      `CHK(nl > 1, 1'b1)
   endtask
   // each clock source: pin use and stop gating, tick rate of the fast ring only
   task automatic t_src;
      int ns, nl;
      logic p;
      reboot(2'h0, 1'b1);
      `CHK(({in_gp, out_gp}), 2'h3)
      count(400, ns, nl);
      `CHK(ns inside {[31:33]}, 1'b1)
      halted(ns);
      `CHK(ns, 0)
      reboot(2'h1, 1'b1);
      `CHK(({in_gp, out_gp, oe}), 3'h1)
      repeat (4) begin
         @(negedge clk);
         p = pin;
         step();
         `CHK(pout, ~p)
      end
      halted(ns);
      `CHK(ns, 0)
      reboot(2'h2, 1'b1);
      `CHK(({in_gp, out_gp, oe}), 3'h2)
      halted(ns);
      `CHK(ns, 0)
      reboot(2'h3, 1'b1);
      `CHK(({in_gp, out_gp, oe}), 3'h6)
   endtask
   task automatic tally_and_finish;
      if (n_fail == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   initial begin
      t_regs();
      t_ratios();
      t_glitch();
      t_slow();
      t_src();
      tally_and_finish();
   end
   // hang guard
   initial begin
      #900000;
      n_fail++;
      tally_and_finish();
   end
endmodule
